// File: rtl/rcl_pkg.sv
// Purpose: Shared constants for the relay channel list interpreter.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package rcl_pkg;
  localparam int ADDR_W = 6;
  localparam int FW = 9;
  localparam int LW = 8;
  localparam int MW = 3;
  localparam int RELAY_N = 256;
  localparam int SEC_W = 8;
  localparam int FLD_STRIDE = 10;
  localparam logic [5:0] OFF_NAME = 6'h00;
  localparam logic [5:0] OFF_START = 6'h04;
  localparam logic [5:0] OFF_STOP = 6'h08;
  localparam logic [5:0] OFF_CMD = 6'h0C;
  localparam logic [5:0] OFF_SECCH = 6'h10;
  localparam logic [5:0] OFF_STAT = 6'h14;
  localparam logic [5:0] OFF_REPLY = 6'h18;
  localparam logic [5:0] OFF_SMASK = 6'h1C;
  localparam logic [2:0] OP_CLOSE = 3'h0;
  localparam logic [2:0] OP_OPEN = 3'h1;
  localparam logic [2:0] OP_QUERY = 3'h2;
  localparam logic [2:0] OP_SCAN = 3'h3;
  localparam logic [2:0] OP_DEFINE = 3'h4;
  localparam logic [2:0] OP_ERRQ = 3'h5;
  localparam logic [2:0] TY_GP = 3'h0;
  localparam logic [2:0] TY_RF = 3'h1;
  localparam logic [2:0] TY_SC6 = 3'h2;
  localparam logic [2:0] TY_SC2 = 3'h3;
  localparam logic [2:0] TY_MX = 3'h4;
  localparam int GP_RL = 64;
  localparam int RF_RL = 4;
  localparam int RF_SEC = 8;
  localparam int SC_RL = 40;
  localparam int SC6_SEC = 6;
  localparam int SC2_SEC = 2;
  localparam int MX_ROW = 4;
  localparam int MX_COL = 16;
  localparam int MX_SEC = 4;
  localparam int MX_ONE = 256;
  localparam int MX_SSPAN = 64;
  localparam int MX_RSPAN = 16;
  localparam int DEC_BASE = 10;
  localparam int STB_MSG = 4;
  localparam int STB_ERR = 2;
  localparam int ESR_CMD = 5;
  localparam int ESR_EXE = 4;
  localparam int STAT_BUSY = 16;
  localparam int STAT_OUT_RDY = 17;
  localparam int CMD_DIM = 4;
  localparam int CMD_MOD = 8;
  localparam int CMD_TY = 12;
  localparam int STOP_RNG = 31;
  localparam int SEC_SCAN = 16;
  localparam int REPLY_VLD = 8;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_SYNTAX = 8'h01;
  localparam logic [7:0] ERR_RANGE = 8'h02;
  localparam logic [7:0] ERR_NAME = 8'h03;
  localparam logic [7:0] CH_LP = 8'h28;
  localparam logic [7:0] CH_RP = 8'h29;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // Default module names are base plus index; the value is arbitrary.
  localparam logic [31:0] NAME_RST_BASE = 32'h0000_0001;
endpackage

// File: rtl/rcl_mem.sv
// Purpose: Small synchronous memory with a registered read port.
// Assumes: One write and one read port on a single clock.
// Notes: A read of the word being written returns the new data.
`timescale 1ns/1ps
module rcl_mem #(
  parameter int W = 8,
  parameter int AW = 4
) (
  // Clock
  input wire logic ref_clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [2**AW];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// File: rtl/rcl_interp.sv
// Purpose: Channel list and section list interpreter with reply queues.
// Assumes: Software feeds pre-split channel groups over AXI4-Lite.
// Notes: One command runs at a time; busy shows it is running.
`timescale 1ns/1ps
module rcl_interp #(
  parameter int NMOD = 6,
  parameter int RQ_AW = 4,
  parameter int EQ_AW = 3,
  parameter int SCAN_AW = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // AXI4-Lite write channels
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [rcl_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // AXI4-Lite read channels
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [rcl_pkg::ADDR_W-1:0] s_araddr,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  // Scan trigger
  input wire logic trig_in,
  // Relay drive and flags
  output logic [NMOD-1:0][rcl_pkg::RELAY_N-1:0] relay_state,
  output logic message_available_bit,
  output logic data_out_ready_bit,
  output logic busy
);
  import rcl_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_MOVE = 3'h4
  } rcl_st_t;
  typedef enum logic [1:0] {
    SP_WAIT = 2'h1,
    SP_LIST = 2'h2
  } rcl_sp_t;

  localparam int SW = MW + 3 + LW;

  logic [31:0] name_reg, start_reg, stop_reg;
  logic [31:0] name_tab [NMOD];
  logic [2:0] type_tab [NMOD];
  logic [SEC_W-1:0] single_tab [NMOD];
  logic [ADDR_W-1:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  logic wr_fire, ar_hs;
  logic [5:0] wa, ra;
  rcl_st_t st_reg, st_next;
  logic [2:0] x_op, x_ty;
  logic [1:0] x_d;
  logic [MW-1:0] x_m;
  logic [FW-1:0] c [3];
  logic [FW-1:0] s [3];
  logic [FW-1:0] e [3];
  logic [FW-1:0] nc [3];
  logic last, adv, stall, scan_full;
  logic [LW-1:0] run_lin;
  logic [2:0] run_sec;
  logic hit;
  logic [MW-1:0] hidx;
  logic lc, l_go, lchan, lbad, lrng;
  logic [2:0] lop, lty;
  logic [1:0] ld;
  logic [MW-1:0] lmod;
  logic e_push, e_cmd, e_exe;
  logic [7:0] e_code;
  logic [7:0] esr_reg;
  rcl_sp_t sp_reg;
  logic [7:0] acc, lo, mn, mx, lo_v, span, macc, smask, ch;
  logic colon, pc, p_syn, p_rng, is_dig, p_end, pscan;
  logic [MW-1:0] pm;
  int smax;
  logic rq_push, rq_pop, rq_full, eq_push, eq_pop, eq_full;
  logic [7:0] rq_wd, rq_rd, eq_rd;
  logic [RQ_AW-1:0] rq_wp, rq_rp, rq_rp_n;
  logic [RQ_AW:0] rq_cnt, rq_cnt_n;
  logic [EQ_AW-1:0] eq_wp, eq_rp, eq_rp_n;
  logic [EQ_AW:0] eq_cnt, eq_cnt_n;
  logic trig_pend, tr_take, tr_go;
  logic [SCAN_AW:0] scan_len;
  logic [SCAN_AW-1:0] scan_ptr, scan_ptr_n;
  logic [SW-1:0] scan_rd;
  logic cl_en, op_en;
  logic [MW-1:0] act_m;
  logic [LW-1:0] act_lin;
  logic [2:0] act_sec, act_ty;
  logic [7:0] stb;
  logic [31:0] rd_mux;

  function automatic logic [FW-1:0] f_fld(input logic [31:0] r, input int i);
    f_fld = r[i*FLD_STRIDE +: FW];
  endfunction

  function automatic logic f_in(input logic [FW-1:0] v, input int lim);
    f_in = (v != '0) && (int'(v) <= lim);
  endfunction

  function automatic logic f_ok(input logic [2:0] ty, input logic [1:0] d,
      input logic [FW-1:0] a, input logic [FW-1:0] b,
      input logic [FW-1:0] k);
    case (ty)
      TY_GP: f_ok = d == 2'h1 && f_in(a, GP_RL);
      TY_RF: f_ok = d == 2'h2 && f_in(a, RF_RL) && f_in(b, RF_SEC);
      TY_SC6: f_ok = d == 2'h2 && f_in(a, SC_RL) && f_in(b, SC6_SEC);
      TY_SC2: f_ok = d == 2'h2 && f_in(a, SC_RL) && f_in(b, SC2_SEC);
      TY_MX: f_ok = (d == 2'h1) ? f_in(a, MX_ONE) : (d == 2'h3 &&
          f_in(a, MX_ROW) && f_in(b, MX_COL) && f_in(k, MX_SEC));
      default: f_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [LW-1:0] f_lin(input logic [2:0] ty,
      input logic [1:0] d, input logic [FW-1:0] a,
      input logic [FW-1:0] b, input logic [FW-1:0] k);
    int t;
    case (ty)
      TY_GP: t = int'(a) - 1;
      TY_RF: t = (int'(b) - 1) * RF_RL + int'(a) - 1;
      TY_SC6, TY_SC2: t = (int'(b) - 1) * SC_RL + int'(a) - 1;
      TY_MX: t = (d == 2'h1) ? int'(a) - 1 : (int'(k) - 1) * MX_SSPAN +
          (int'(a) - 1) * MX_RSPAN + int'(b) - 1;
      default: t = 0;
    endcase
    f_lin = LW'(t);
  endfunction

  function automatic logic [31:0] f_wr(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = sb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    f_wr = old;
  endfunction

  assign wr_fire = !s_awready && !s_wready && !s_bvalid;
  assign ar_hs = s_arvalid && s_arready;
  assign wa = {aw_a[ADDR_W-1:2], 2'h0};
  assign ra = {s_araddr[ADDR_W-1:2], 2'h0};

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      aw_a <= '0;
      w_d <= '0;
      w_s <= '0;
    end else begin
      if (s_awvalid && s_awready) begin
        s_awready <= 1'b0;
        aw_a <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        s_wready <= 1'b0;
        w_d <= s_wdata;
        w_s <= s_wstrb;
      end
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp <= (wa > OFF_SMASK) ? RESP_DECERR : RESP_OKAY;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      name_reg <= '0;
      start_reg <= '0;
      stop_reg <= '0;
    end else if (wr_fire) begin
      if (wa == OFF_NAME) name_reg <= f_wr(name_reg, w_d, w_s);
      if (wa == OFF_START) start_reg <= f_wr(start_reg, w_d, w_s);
      if (wa == OFF_STOP) stop_reg <= f_wr(stop_reg, w_d, w_s);
    end
  end

  always_comb begin
    stb = '0;
    stb[STB_MSG] = rq_cnt != '0;
    stb[STB_ERR] = eq_cnt != '0;
    rd_mux = '0;
    case (ra)
      OFF_NAME: rd_mux = name_reg;
      OFF_START: rd_mux = start_reg;
      OFF_STOP: rd_mux = stop_reg;
      OFF_STAT: rd_mux = {14'h0000, data_out_ready_bit, busy, esr_reg, stb};
      OFF_REPLY: rd_mux = {23'h00_0000, rq_cnt != '0, rq_rd};
      OFF_SMASK: rd_mux = {24'h00_0000, smask};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_mux;
      s_rresp <= (ra > OFF_SMASK) ? RESP_DECERR : RESP_OKAY;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  always_comb begin
    hit = 1'b0;
    hidx = '0;
    for (int i = 0; i < NMOD; i++) begin
      if (name_tab[i] == name_reg) begin
        hit = 1'b1;
        hidx = MW'(i);
      end
    end
  end

  always_comb begin
    lc = wr_fire && wa == OFF_CMD && st_reg == ST_IDLE;
    lop = w_d[2:0];
    ld = w_d[CMD_DIM +: 2];
    lmod = w_d[CMD_MOD +: MW];
    lty = w_d[CMD_TY +: 3];
    lrng = stop_reg[STOP_RNG];
    lchan = lop inside {OP_CLOSE, OP_OPEN, OP_QUERY, OP_SCAN};
    lbad = !f_ok(type_tab[hidx], ld, f_fld(start_reg, 0),
        f_fld(start_reg, 1), f_fld(start_reg, 2)) ||
        (lrng && !f_ok(type_tab[hidx], ld, f_fld(stop_reg, 0),
        f_fld(stop_reg, 1), f_fld(stop_reg, 2)));
    l_go = lc && lchan && hit && !lbad;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NMOD; i++) begin
        name_tab[i] <= NAME_RST_BASE + 32'(i);
        type_tab[i] <= TY_GP;
      end
    end else if (lc && lop == OP_DEFINE && int'(lmod) < NMOD) begin
      name_tab[lmod] <= name_reg;
      type_tab[lmod] <= lty;
    end
  end

  always_comb begin
    last = 1'b1;
    for (int i = 2; i >= 0; i--) begin
      nc[i] = c[i];
      if (i < int'(x_d) && last) begin
        if (c[i] != e[i]) begin
          nc[i] = (c[i] < e[i]) ? c[i] + FW'(1) : c[i] - FW'(1);
          last = 1'b0;
        end else begin
          nc[i] = s[i];
        end
      end
    end
    run_lin = f_lin(x_ty, x_d, c[0], c[1], c[2]);
    run_sec = (x_ty == TY_GP || x_ty == TY_MX) ? 3'h0 : 3'(c[1] - FW'(1));
    scan_full = x_op == OP_SCAN && scan_len[SCAN_AW];
    stall = x_op == OP_QUERY && rq_full;
    adv = st_reg == ST_RUN && !stall;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      x_op <= OP_CLOSE;
      x_ty <= TY_GP;
      x_d <= '0;
      x_m <= '0;
      for (int i = 0; i < 3; i++) begin
        c[i] <= '0;
        s[i] <= '0;
        e[i] <= '0;
      end
    end else if (l_go) begin
      x_op <= lop;
      x_ty <= type_tab[hidx];
      x_d <= ld;
      x_m <= hidx;
      for (int i = 0; i < 3; i++) begin
        c[i] <= f_fld(start_reg, i);
        s[i] <= f_fld(start_reg, i);
        e[i] <= lrng ? f_fld(stop_reg, i) : f_fld(start_reg, i);
      end
    end else if (adv) begin
      for (int i = 0; i < 3; i++) begin
        c[i] <= nc[i];
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (l_go) st_next = ST_RUN;
        else if (lc && lop == OP_ERRQ) st_next = ST_MOVE;
      end
      ST_RUN: if (adv && (last || scan_full)) st_next = ST_IDLE;
      ST_MOVE: if (!rq_full) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_IDLE;
      busy <= 1'b0;
    end else begin
      st_reg <= st_next;
      busy <= st_next != ST_IDLE;
    end
  end

  always_comb begin
    ch = w_d[7:0];
    pm = w_d[CMD_MOD +: MW];
    pscan = w_d[SEC_SCAN];
    pc = wr_fire && wa == OFF_SECCH && st_reg == ST_IDLE;
    is_dig = ch >= CH_0 && ch <= CH_9;
    p_end = ch == CH_COMMA || ch == CH_RP;
    lo_v = colon ? lo : acc;
    mn = (lo_v < acc) ? lo_v : acc;
    mx = (lo_v < acc) ? acc : lo_v;
    smax = 0;
    if (int'(pm) < NMOD && type_tab[pm] == TY_SC6) smax = SC6_SEC;
    if (int'(pm) < NMOD && type_tab[pm] == TY_SC2) smax = SC2_SEC;
    for (int i = 0; i < SEC_W; i++) begin
      span[i] = (i + 1 >= int'(mn)) && (i + 1 <= int'(mx));
    end
    p_syn = pc && ((sp_reg == SP_WAIT && ch != CH_LP) ||
        (sp_reg == SP_LIST && !is_dig && !p_end &&
        (ch != CH_COLON || colon)));
    p_rng = pc && sp_reg == SP_LIST && p_end &&
        (mn == '0 || int'(mx) > smax);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sp_reg <= SP_WAIT;
      acc <= '0;
      lo <= '0;
      colon <= 1'b0;
      macc <= '0;
      smask <= '0;
      for (int i = 0; i < NMOD; i++) single_tab[i] <= '0;
    end else if (pc) begin
      case (sp_reg)
        SP_WAIT: begin
          if (ch == CH_LP) begin
            sp_reg <= SP_LIST;
            acc <= '0;
            colon <= 1'b0;
            macc <= '0;
          end
        end
        SP_LIST: begin
          if (p_syn || p_rng) begin
            sp_reg <= SP_WAIT;
          end else if (is_dig) begin
            acc <= LW'(int'(acc) * DEC_BASE + int'(ch - CH_0));
          end else if (ch == CH_COLON) begin
            lo <= acc;
            colon <= 1'b1;
            acc <= '0;
          end else begin
            macc <= macc | span;
            acc <= '0;
            colon <= 1'b0;
            if (ch == CH_RP) begin
              sp_reg <= SP_WAIT;
              smask <= macc | span;
              if (pscan) single_tab[pm] <= macc | span;
            end
          end
        end
        default: sp_reg <= SP_WAIT;
      endcase
    end
  end

  always_comb begin
    e_push = 1'b0;
    e_code = ERR_NONE;
    if (lc && lchan && !hit) begin
      e_push = 1'b1;
      e_code = ERR_NAME;
    end else if (lc && lchan && lbad) begin
      e_push = 1'b1;
      e_code = ERR_RANGE;
    end else if (lc && lop == OP_DEFINE && int'(lmod) >= NMOD) begin
      e_push = 1'b1;
      e_code = ERR_RANGE;
    end else if (lc && !lchan && lop != OP_DEFINE && lop != OP_ERRQ) begin
      e_push = 1'b1;
      e_code = ERR_SYNTAX;
    end else if (p_syn) begin
      e_push = 1'b1;
      e_code = ERR_SYNTAX;
    end else if (p_rng || (adv && scan_full)) begin
      e_push = 1'b1;
      e_code = ERR_RANGE;
    end
    e_cmd = e_push && e_code != ERR_RANGE;
    e_exe = e_push && e_code == ERR_RANGE;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      esr_reg <= '0;
    end else begin
      esr_reg <= (esr_reg & ~((wr_fire && wa == OFF_STAT) ? w_d[15:8] : 8'h00))
          | (8'(e_cmd) << ESR_CMD) | (8'(e_exe) << ESR_EXE);
    end
  end

  always_comb begin
    eq_full = eq_cnt[EQ_AW];
    eq_push = e_push && !eq_full;
    rq_full = rq_cnt[RQ_AW];
    eq_pop = st_reg == ST_MOVE && !rq_full && eq_cnt != '0;
    rq_push = (adv && x_op == OP_QUERY) || (st_reg == ST_MOVE && !rq_full);
    rq_wd = (st_reg == ST_MOVE) ? ((eq_cnt != '0) ? eq_rd : ERR_NONE) :
        CH_0 + 8'(relay_state[x_m][run_lin]);
    rq_pop = ar_hs && ra == OFF_REPLY && rq_cnt != '0;
    rq_rp_n = rq_rp + RQ_AW'(rq_pop);
    eq_rp_n = eq_rp + EQ_AW'(eq_pop);
    rq_cnt_n = rq_cnt + (RQ_AW + 1)'(rq_push) - (RQ_AW + 1)'(rq_pop);
    eq_cnt_n = eq_cnt + (EQ_AW + 1)'(eq_push) - (EQ_AW + 1)'(eq_pop);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rq_wp <= '0;
      rq_rp <= '0;
      rq_cnt <= '0;
      eq_wp <= '0;
      eq_rp <= '0;
      eq_cnt <= '0;
      message_available_bit <= 1'b0;
      data_out_ready_bit <= 1'b0;
    end else begin
      rq_wp <= rq_wp + RQ_AW'(rq_push);
      rq_rp <= rq_rp_n;
      rq_cnt <= rq_cnt_n;
      eq_wp <= eq_wp + EQ_AW'(eq_push);
      eq_rp <= eq_rp_n;
      eq_cnt <= eq_cnt_n;
      message_available_bit <= rq_cnt_n != '0;
      data_out_ready_bit <= rq_cnt_n != '0;
    end
  end

  rcl_mem #(.W(8), .AW(RQ_AW)) u_reply (
    .ref_clk(ref_clk),
    .we(rq_push),
    .waddr(rq_wp),
    .wdata(rq_wd),
    .raddr(rq_rp_n),
    .rdata(rq_rd)
  );

  rcl_mem #(.W(8), .AW(EQ_AW)) u_error (
    .ref_clk(ref_clk),
    .we(eq_push),
    .waddr(eq_wp),
    .wdata(e_code),
    .raddr(eq_rp_n),
    .rdata(eq_rd)
  );

  always_comb begin
    tr_take = st_reg == ST_IDLE && !wr_fire;
    tr_go = tr_take && trig_pend && scan_len != '0;
    scan_ptr_n = scan_ptr;
    if (l_go && lop == OP_SCAN) begin
      scan_ptr_n = '0;
    end else if (tr_go) begin
      scan_ptr_n = ((SCAN_AW + 1)'(scan_ptr) + 1'b1 == scan_len) ? '0 :
          scan_ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_pend <= 1'b0;
      scan_len <= '0;
      scan_ptr <= '0;
    end else begin
      trig_pend <= trig_in || (trig_pend && !tr_take);
      scan_ptr <= scan_ptr_n;
      if (l_go && lop == OP_SCAN) begin
        scan_len <= '0;
      end else if (adv && x_op == OP_SCAN && !scan_full) begin
        scan_len <= scan_len + 1'b1;
      end
    end
  end

  rcl_mem #(.W(SW), .AW(SCAN_AW)) u_scan (
    .ref_clk(ref_clk),
    .we(adv && x_op == OP_SCAN && !scan_full),
    .waddr(scan_len[SCAN_AW-1:0]),
    .wdata({x_m, run_sec, run_lin}),
    .raddr(scan_ptr_n),
    .rdata(scan_rd)
  );

  always_comb begin
    act_m = tr_go ? scan_rd[SW-1 -: MW] : x_m;
    act_sec = tr_go ? scan_rd[LW +: 3] : run_sec;
    act_lin = tr_go ? scan_rd[LW-1:0] : run_lin;
    act_ty = type_tab[act_m];
    cl_en = tr_go || (adv && x_op == OP_CLOSE);
    op_en = adv && x_op == OP_OPEN;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      relay_state <= '0;
    end else if (cl_en) begin
      if (act_ty == TY_RF) begin
        relay_state[act_m][LW'(int'(act_sec) * RF_RL) +: RF_RL] <= '0;
      end
      if ((act_ty == TY_SC6 || act_ty == TY_SC2) &&
          single_tab[act_m][act_sec]) begin
        relay_state[act_m] <= '0;
      end
      relay_state[act_m][act_lin] <= 1'b1;
    end else if (op_en) begin
      relay_state[act_m][act_lin] <= 1'b0;
    end
  end
endmodule

// File: verification/rcl_interp_asserts.sv
// Purpose: Port checks for the interpreter.
// Assumes: Sees only rcl_interp ports.
// Notes: Reset is asynchronous, active low.
`timescale 1ns/1ps
module rcl_interp_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Bus
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [5:0] s_araddr,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  // Flags
  input wire logic message_available_bit,
  input wire logic data_out_ready_bit
);
  import rcl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_flags_match:
    assert property (message_available_bit == data_out_ready_bit)
    else $error("flags differ");
  a_rvalid_hold:
    assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read dropped");
  a_bvalid_hold:
    assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write dropped");
  a_rd_answer:
    assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("no read answer");
  a_rd_decerr:
    assert property (s_arvalid && s_arready &&
      {s_araddr[5:2], 2'h0} > OFF_SMASK
      |=> s_rresp == RESP_DECERR) else $error("bad read taken");
  a_rd_okay:
    assert property (s_arvalid && s_arready &&
      {s_araddr[5:2], 2'h0} <= OFF_SMASK
      |=> s_rresp == RESP_OKAY) else $error("good read refused");
  a_reply_valid:
    assert property (s_arvalid && s_arready &&
      {s_araddr[5:2], 2'h0} == OFF_REPLY
      |=> s_rdata[8] == $past(data_out_ready_bit))
    else $error("reply valid bit differs from flag");
  a_ar_blocked:
    assert property (s_rvalid |-> !s_arready) else $error("arready early");
  a_rd_clear:
    assert property (s_rvalid && s_rready |=> !s_rvalid)
    else $error("read repeated");
endmodule

// File: verification/rcl_cmdr.sv
// Purpose: Commander model on the register bus.
// Assumes: One read and one write at a time.
// Notes: Replies are read only while data-out-ready is set.
`timescale 1ns/1ps
module rcl_cmdr (
  // Clock
  input wire logic ref_clk,
  // Write
  output logic s_awvalid,
  input wire logic s_awready,
  output logic [5:0] s_awaddr,
  output logic s_wvalid,
  input wire logic s_wready,
  output logic [31:0] s_wdata,
  output logic [3:0] s_wstrb,
  input wire logic s_bvalid,
  output logic s_bready,
  // Read
  output logic s_arvalid,
  input wire logic s_arready,
  output logic [5:0] s_araddr,
  input wire logic s_rvalid,
  output logic s_rready,
  input wire logic [31:0] s_rdata
);
  import rcl_pkg::*;
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    {s_awaddr, s_wdata, s_wstrb} <= {a, v, 4'hF};
    do begin
      @(posedge ref_clk);
      if (s_awready) s_awvalid <= 0;
      if (s_wready) s_wvalid <= 0;
    end while (!s_bvalid);
    s_bready <= 0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    {s_arvalid, s_rready, s_araddr} <= {2'b11, a};
    do begin
      @(posedge ref_clk);
      if (s_arready) s_arvalid <= 0;
    end while (!s_rvalid);
    v = s_rdata;
    s_rready <= 0;
  endtask
  task automatic cmd(input logic [31:0] c);
    logic [31:0] s;
    wr(OFF_CMD, c);
    s = 32'h0001_0000;
    while (s[STAT_BUSY] !== 1'b0) rd(OFF_STAT, s);
  endtask
  task automatic reply(output logic [31:0] v);
    logic [31:0] s;
    s = 0;
    while (s[STAT_OUT_RDY] !== 1'b1) rd(OFF_STAT, s);
    rd(OFF_REPLY, v);
  endtask
endmodule

// File: verification/tb_rcl_interp.sv
// Purpose: Self-checking bench for the interpreter.
// Assumes: The commander model drives the bus.
// Notes: Module defines, then table of closes, then hand cases.
`timescale 1ns/1ps
module tb_rcl_interp;
  import rcl_pkg::*;
  typedef struct {int nm; int st; int dm; int md; int ix;} rcl_row_t;
  localparam logic [31:0] RG = 32'h8000_0000;
  logic ref_clk = 0;
  logic rst_b = 0;
  logic trig_in = 0;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, busy;
  logic message_available_bit, data_out_ready_bit;
  logic [5:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  string sl = "(1:3,5:6)";
  logic [5:0][RELAY_N-1:0] rs;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  rcl_row_t rows [4] = '{'{3, 10, 1, 2, 9}, '{4, 64, 1, 3, 63},
    '{119, 65, 1, 5, 64}, '{119, 3 << 20 | 13 << 10 | 1, 3, 5, 140}};
  always #4 ref_clk = ~ref_clk;
  rcl_interp uut (.ref_clk, .rst_b, .s_awvalid, .s_awready, .s_awaddr,
    .s_wvalid, .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready,
    .s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready,
    .s_rdata, .s_rresp, .trig_in, .relay_state(rs),
    .message_available_bit, .data_out_ready_bit, .busy);
  rcl_cmdr cmdr (.ref_clk, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
    .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_arvalid,
    .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata);
  function automatic logic [31:0] f(int a, int b, int c);
    return (32'(c) << 20) | (32'(b) << 10) | 32'(a);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chan(input logic [31:0] nm, st, sp, input int dm, op);
    cmdr.wr(OFF_NAME, nm);
    cmdr.wr(OFF_START, st);
    cmdr.wr(OFF_STOP, sp);
    cmdr.cmd(32'(op) | (32'(dm) << CMD_DIM));
  endtask
  task automatic qry(input logic [31:0] nm, st, sp, input int dm,
      input logic [3:0] e);
    chan(nm, st, sp | RG, dm, OP_QUERY);
    chk(message_available_bit, 1);
    for (int i = 3; i >= 0; i--) begin
      cmdr.reply(d);
      chk(d, 32'h0000_0130 | e[i]);
    end
    chk(message_available_bit, 0);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1;
    chk(message_available_bit | busy | (|rs), 0);
    cmdr.rd(OFF_STAT, d);
    chk(d, 0);
    cmdr.wr(OFF_NAME, 32'h0000_0077);
    cmdr.cmd(32'h0000_4504);
    cmdr.wr(OFF_NAME, 32'h0000_0001);
    cmdr.cmd(32'h0000_1004);
    cmdr.wr(OFF_NAME, 32'h0000_0002);
    cmdr.cmd(32'h0000_2104);
    foreach (rows[i]) begin
      chan(rows[i].nm, rows[i].st, rows[i].st, rows[i].dm, OP_CLOSE);
      chk(rs[rows[i].md][rows[i].ix], 1);
    end
    chan(119, f(1, 2, 1), f(1, 2, 1), 3, OP_CLOSE);
    qry(119, f(1, 1, 1), f(1, 2, 2), 3, 4'b0110);
    chan(1, f(1, 1, 0), f(3, 1, 0) | RG, 2, OP_CLOSE);
    chk(rs[0][2:0], 3'b100);
    chan(1, f(2, 1, 0), f(2, 1, 0), 2, OP_CLOSE);
    qry(1, f(1, 1, 0), f(2, 2, 0), 2, 4'b0010);
    qry(3, 11, 8, 1, 4'b0100);
    foreach (sl[i])
      cmdr.wr(OFF_SECCH, 32'h0001_0100 | 32'(sl[i]));
    cmdr.rd(OFF_SMASK, d);
    chk(d, 32'h0000_0037);
    chk(s_bresp, RESP_OKAY);
    chan(2, f(1, 1, 0), f(1, 6, 0) | RG, 2, OP_CLOSE);
    chk(rs[1] === (256'h1 << 200), 1);
    chan(3, 65, 65, 1, OP_CLOSE);
    cmdr.cmd(32'h0000_0007);
    cmdr.rd(OFF_STAT, d);
    chk(d & 32'h0000_3014, 32'h0000_3004);
    for (int i = 2; i > 0; i--) begin
      cmdr.cmd(OP_ERRQ);
      cmdr.reply(d);
      chk(d, 32'h0000_0100 | i);
    end
    cmdr.rd(OFF_STAT, d);
    chk(d & 32'h0000_0014, 0);
    cmdr.rd(6'h20, d);
    chk(s_rresp, RESP_DECERR);
    cmdr.wr(6'h20, 32'h0000_0000);
    chk(s_bresp, RESP_DECERR);
    chan(3, 7, 5 | RG, 1, OP_SCAN);
    for (int i = 6; i > 4; i--) begin
      @(posedge ref_clk) trig_in <= 1;
      @(posedge ref_clk) trig_in <= 0;
      repeat (3) @(posedge ref_clk);
      chk({rs[2][i], rs[2][i-1]}, 2'b10);
    end
    rst_b <= 0;
    @(posedge ref_clk) rst_b <= 1;
    chk(|rs, 0);
    cmdr.rd(OFF_STAT, d);
    chk(d, 0);
    stop_test();
  end
endmodule
bind rcl_interp rcl_interp_asserts u_chk (.ref_clk, .rst_b, .s_bvalid,
  .s_bready, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready,
  .s_rdata, .s_rresp, .message_available_bit, .data_out_ready_bit);
